// *** include/iora_pkg.sv ***
package iora_pkg;
    localparam int unsigned ADDR_W        = 20;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned BE_W          = 4;
    // 128 KB internal register and memory space
    localparam logic [19:0] REG_SPACE_LAST = 20'h1ffff;
    // flash region size, 64 KB to 512 KB; largest taken
    localparam logic [19:0] FLASH_LAST_OFS = 20'h7ffff;
    // pointer decode for the flash range
    localparam logic [19:0] PTR_FLASH_FIRST = 20'h80000;
    // 32-byte I/O window
    localparam logic [19:0] IO_WIN_LAST   = 20'h0001f;
    localparam logic [19:0] IO_PTR_OFS    = 20'h00000;
    localparam logic [19:0] IO_DATA_OFS   = 20'h00004;
    localparam logic [19:0] IO_RSVD_FIRST = 20'h00008;
    localparam logic [19:0] PTR_RESET     = 20'h00000;
    localparam logic [11:0] PTR_UPPER     = 12'h000;
    localparam logic [31:0] RSVD_RDATA    = 32'h0000ffff;
    localparam logic [31:0] NO_DATA       = 32'h00000000;
    localparam logic [3:0]  BE_FULL       = 4'hf;
    localparam logic [1:0]  LANE_ZERO     = 2'h0;

    typedef enum logic [1:0] {
        IORA_RGN_REG,
        IORA_RGN_FLASH,
        IORA_RGN_ROM,
        IORA_RGN_IO
    } iora_region_t;

    typedef struct packed {
        logic         nvm_flash_en;
        logic         flash_base_nz;
        logic         rom_base_nz;
        logic         io_base_nz;
        logic         io_decode_en;
    } iora_cfg_t;

    typedef struct packed {
        logic         valid;
        logic         write;
        iora_region_t region;
        logic [19:0]  addr;
        logic [3:0]   be;
        logic [31:0]  wdata;
    } iora_host_req_t;

    typedef struct packed {
        logic         valid;
        logic         hit;
        logic [31:0]  rdata;
    } iora_host_rsp_t;

    typedef struct packed {
        logic         valid;
        logic         write;
        logic         flash;
        logic [19:0]  addr;
        logic [3:0]   be;
        logic [31:0]  wdata;
    } iora_back_req_t;
endpackage

// *** core/iora_top.sv ***
`timescale 1ns/1ps
// Function
// RULE1: decode 128 KB internal register space
// RULE2: flash and ROM regions reach same flash
// RULE3: I/O base maps a 32-byte window
// RULE4: drop partial writes to 32-bit registers
// RULE5: partial register reads return full word
// RULE6: flash accepts byte, word, dword accesses
// RULE7: host writes no ones to reserved bits
// RULE8: host writes no undeclared addresses
// RULE9: counters read as 32-bit halves only
// RULE10: flash region needs enable and nonzero base
// RULE11: ROM region needs enable and nonzero base
// RULE12: I/O needs nonzero base and decode enable
// RULE13: pointer at offset 0, data at 4
// RULE14: pointer decode: regs, undefined, flash
// RULE15: data window forwards to pointed location
// RULE16: pointer writes need all byte enables
// RULE17: pointer bits 31..20 read zero
// RULE18: pointer clears on reset, holds otherwise
// RULE19: host avoids partial reads
// RULE20: reserved window offsets read ffff, ignore writes
// RULE21: narrow data writes to registers ignored
// RULE22: flash data writes use aligned enables
// RULE23: host pairs pointer and data atomically
module iora_top (
    input  wire logic                    i_clock,
    input  wire logic                    i_reset_n,
    input  wire iora_pkg::iora_cfg_t      i_cfg,
    input  wire iora_pkg::iora_host_req_t i_host_req,
    input  wire logic                    i_back_done,
    input  wire logic [31:0]             i_back_rdata,
    output logic                         o_host_ready,
    output iora_pkg::iora_host_rsp_t      o_host_rsp,
    output iora_pkg::iora_back_req_t      o_back_req,
    output logic [19:0]                  o_io_address_pointer
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_sync1_ff;
    logic rst_sync2_ff;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end

    assign rst_n = rst_sync2_ff;

    ////////////////////////////////////////////////////////////////////////
    // request decode
    typedef enum logic {
        IORA_ST_IDLE,
        IORA_ST_BACK
    } iora_state_t;

    iora_state_t state_ff;
    iora_state_t nxt_state;

    logic        take;
    logic        be_full;
    logic        flash_ok;
    logic        rom_ok;
    logic        io_ok;
    logic        ptr_is_reg;
    logic        ptr_is_flash;
    logic        lanes_ok;
    logic [1:0]  be_low_lane;
    logic [19:0] ptr_ff;
    logic [19:0] nxt_ptr;

    assign take    = i_host_req.valid && o_host_ready;
    assign be_full = (i_host_req.be == iora_pkg::BE_FULL);
    assign flash_ok = i_cfg.nvm_flash_en && i_cfg.flash_base_nz;           // [RULE10]
    assign rom_ok   = i_cfg.nvm_flash_en && i_cfg.rom_base_nz;             // [RULE11]
    assign io_ok    = i_cfg.io_base_nz && i_cfg.io_decode_en;              // [RULE12]
    assign ptr_is_reg   = (ptr_ff <= iora_pkg::REG_SPACE_LAST);            // [RULE14]
    assign ptr_is_flash = (ptr_ff >= iora_pkg::PTR_FLASH_FIRST);           // [RULE14]

    // lowest enabled lane must match the pointer's low bits unless all four lanes are enabled
    always_comb begin
        be_low_lane = 2'h3;
        for (int i = 3; i >= 0; i--) begin
            if (i_host_req.be[i]) begin
                be_low_lane = 2'(i);
            end
        end
    end

    assign lanes_ok = (be_low_lane == ptr_ff[1:0]) || be_full;              // [RULE22]

    ////////////////////////////////////////////////////////////////////////
    // pointer register

    always_comb begin
        nxt_ptr = ptr_ff;                                                   // [RULE18]
        if (take && i_host_req.write && io_ok
            && i_host_req.region == iora_pkg::IORA_RGN_IO
            && i_host_req.addr == iora_pkg::IO_PTR_OFS                      // [RULE13]
            && be_full) begin                                               // [RULE16]
            nxt_ptr = i_host_req.wdata[19:0];                               // [RULE17]
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff <= iora_pkg::PTR_RESET;                                  // [RULE18]
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transaction control
    iora_pkg::iora_back_req_t back_ff;
    iora_pkg::iora_back_req_t nxt_back;
    iora_pkg::iora_host_rsp_t rsp_ff;
    iora_pkg::iora_host_rsp_t nxt_rsp;
    logic                     ready_ff;
    logic                     nxt_ready;

    always_comb begin
        nxt_state = state_ff;
        nxt_back  = back_ff;
        nxt_rsp   = '0;
        nxt_back.valid = 1'b0;
        case (state_ff)
            IORA_ST_IDLE: begin
                if (take) begin
                    nxt_back.write = i_host_req.write;
                    nxt_back.wdata = i_host_req.wdata;
                    nxt_back.be    = i_host_req.be;
                    nxt_back.addr  = i_host_req.addr;
                    nxt_back.flash = 1'b0;
                    nxt_rsp.valid  = 1'b1;
                    nxt_rsp.hit    = 1'b1;
                    nxt_rsp.rdata  = iora_pkg::NO_DATA;
                    case (i_host_req.region)
                        iora_pkg::IORA_RGN_REG: begin
                            if (i_host_req.addr > iora_pkg::REG_SPACE_LAST) begin   // [RULE1]
                                nxt_rsp.hit = 1'b0;
                            end else if (i_host_req.write && !be_full) begin
                                nxt_rsp.hit = 1'b1;                        // [RULE4]
                            end else begin
                                nxt_back.valid = 1'b1;
                                nxt_back.be    = iora_pkg::BE_FULL;        // [RULE5] [RULE9]
                                nxt_back.addr[1:0] = iora_pkg::LANE_ZERO;
                            end
                        end
                        iora_pkg::IORA_RGN_FLASH,
                        iora_pkg::IORA_RGN_ROM: begin
                            if (((i_host_req.region == iora_pkg::IORA_RGN_FLASH)
                                     ? flash_ok : rom_ok)
                                && i_host_req.addr <= iora_pkg::FLASH_LAST_OFS) begin
                                nxt_back.valid = 1'b1;                     // [RULE2] [RULE6]
                                nxt_back.flash = 1'b1;                     // [RULE10] [RULE11]
                            end else begin
                                nxt_rsp.hit = 1'b0;
                            end
                        end
                        iora_pkg::IORA_RGN_IO: begin
                            if (!io_ok || i_host_req.addr > iora_pkg::IO_WIN_LAST) begin
                                nxt_rsp.hit = 1'b0;                        // [RULE3] [RULE12]
                            end else if (i_host_req.addr >= iora_pkg::IO_RSVD_FIRST) begin
                                nxt_rsp.rdata = iora_pkg::RSVD_RDATA;      // [RULE20]
                            end else if (i_host_req.addr[2] == iora_pkg::IO_PTR_OFS[2]) begin
                                nxt_rsp.rdata = {iora_pkg::PTR_UPPER, ptr_ff};  // [RULE16] [RULE17]
                            end else if (ptr_is_reg) begin
                                if (!i_host_req.write || be_full) begin    // [RULE21]
                                    nxt_back.valid = 1'b1;                 // [RULE15]
                                    nxt_back.addr  = {ptr_ff[19:2], iora_pkg::LANE_ZERO};
                                    nxt_back.be    = iora_pkg::BE_FULL;    // [RULE5]
                                end
                            end else if (ptr_is_flash) begin
                                if (!i_host_req.write || lanes_ok) begin   // [RULE22]
                                    nxt_back.valid = 1'b1;                 // [RULE15] [RULE6]
                                    nxt_back.flash = 1'b1;
                                    nxt_back.addr  = {ptr_ff[19:2], iora_pkg::LANE_ZERO};
                                    nxt_back.be    = i_host_req.write
                                                     ? i_host_req.be : iora_pkg::BE_FULL;
                                end
                            end
                        end
                        default: begin
                            nxt_rsp.hit = 1'b0;
                        end
                    endcase
                    if (nxt_back.valid) begin
                        nxt_rsp   = '0;
                        nxt_state = IORA_ST_BACK;
                    end
                end
            end
            IORA_ST_BACK: begin
                if (i_back_done) begin
                    nxt_rsp.valid = 1'b1;
                    nxt_rsp.hit   = 1'b1;
                    nxt_rsp.rdata = back_ff.write ? iora_pkg::NO_DATA : i_back_rdata;
                    nxt_state     = IORA_ST_IDLE;
                end
            end
            default: begin
                nxt_state = IORA_ST_IDLE;
            end
        endcase
        nxt_ready = (nxt_state == IORA_ST_IDLE);
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= IORA_ST_IDLE;
            back_ff  <= '0;
            rsp_ff   <= '0;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            back_ff  <= nxt_back;
            rsp_ff   <= nxt_rsp;
            ready_ff <= nxt_ready;
        end
    end

    assign o_host_ready         = ready_ff;
    assign o_host_rsp           = rsp_ff;
    assign o_back_req           = back_ff;
    assign o_io_address_pointer = ptr_ff;

endmodule

// *** testbench/iora_top_chk.sv ***
`timescale 1ns/1ps
module iora_top_chk (
    input wire logic                     i_clock,
    input wire logic                     i_reset_n,
    input wire iora_pkg::iora_cfg_t      i_cfg,
    input wire iora_pkg::iora_host_req_t i_host_req,
    input wire logic                     i_back_done,
    input wire logic [31:0]              i_back_rdata,
    input wire logic                     o_host_ready,
    input wire iora_pkg::iora_host_rsp_t o_host_rsp,
    input wire iora_pkg::iora_back_req_t o_back_req,
    input wire logic [19:0]              o_io_address_pointer
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    logic        tk, io, pw, rg, miss;
    logic [19:0] wlo;
    assign wlo = i_host_req.wdata[19:0];
    assign tk = i_host_req.valid & o_host_ready;
    assign io = tk & i_host_req.region == 2'h3 & i_cfg.io_base_nz & i_cfg.io_decode_en;
    assign pw = io & i_host_req.write & i_host_req.addr[4:2] == 3'h0;
    assign rg = tk & i_host_req.region == 2'h0 & i_host_req.addr <= iora_pkg::REG_SPACE_LAST;
    assign miss = tk & (i_host_req.region == 2'h1 & !(i_cfg.nvm_flash_en & i_cfg.flash_base_nz)
        | i_host_req.region == 2'h2 & !(i_cfg.nvm_flash_en & i_cfg.rom_base_nz)
        | i_host_req.region == 2'h3 & !(i_cfg.io_base_nz & i_cfg.io_decode_en));
    // forwarded read, then the back end answers
    sequence s_fwd;
        (o_back_req.valid && !o_back_req.write) ##[1:8] i_back_done;
    endsequence
    chk_ptr_load: assert property (pw && i_host_req.be == 4'hf |=>
        o_io_address_pointer == $past(wlo)) else $error("pointer not loaded");
    chk_ptr_part: assert property (pw && i_host_req.be != 4'hf |=>
        $stable(o_io_address_pointer)) else $error("partial pointer write taken");
    chk_ptr_hold: assert property ($changed(o_io_address_pointer) |-> $past(pw))
        else $error("pointer changed without write");
    chk_rsvd_read: assert property (io && !i_host_req.write && i_host_req.addr[4:3] != 2'h0 |=>
        o_host_rsp.valid && o_host_rsp.rdata == iora_pkg::RSVD_RDATA) else $error("reserved read");
    chk_reg_part: assert property (rg && i_host_req.write && i_host_req.be != 4'hf |=>
        o_host_rsp.valid && !o_back_req.valid) else $error("partial register write passed");
    chk_off_miss: assert property (miss |=> o_host_rsp.valid && !o_host_rsp.hit
        && o_host_rsp.rdata == 32'h0) else $error("disabled region answered");
    chk_reg_fwd: assert property (rg && !i_host_req.write |=>
        o_back_req.valid && !o_back_req.flash) else $error("register read not forwarded");
    chk_fwd_reply: assert property (s_fwd |=> o_host_rsp.valid
        && o_host_rsp.rdata == $past(i_back_rdata)) else $error("forwarded data lost");
endmodule
bind iora_top iora_top_chk u_iora_top_chk (.i_clock, .i_reset_n, .i_cfg, .i_host_req,
    .i_back_done, .i_back_rdata, .o_host_ready, .o_host_rsp, .o_back_req, .o_io_address_pointer);

// *** testbench/iora_back_model.sv ***
`timescale 1ns/1ps
module iora_back_model (
    input  wire logic                     i_clock,
    input  wire iora_pkg::iora_back_req_t i_req,
    input  wire logic [1:0]               i_lag,
    output logic                          o_done,
    output logic [31:0]                   o_rdata
);
    logic [31:0] mem [int];
    logic [31:0] w;
    int          k;
    initial begin
        o_done = 1'b0;
        o_rdata = 32'h0;
        forever begin
            @(posedge i_clock);
            if (i_req.valid) begin
                // both flash regions alias one offset space
                k = {i_req.flash, i_req.addr[18:2]};
                w = mem.exists(k) ? mem[k] : 32'h0;
                for (int b = 0; b < 4; b++)
                    if (i_req.write && i_req.be[b]) w[8*b+:8] = i_req.wdata[8*b+:8];
                mem[k] = w;
                repeat (i_lag) @(posedge i_clock);
                o_done <= 1'b1;
                o_rdata <= w;
                @(posedge i_clock);
                o_done <= 1'b0;
                o_rdata <= ~w;
            end
        end
    end
endmodule

// *** testbench/iora_top_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED %0t got %h", $time, a); end end
module iora_top_bench;
    logic                     i_clock = 1'b0;
    logic                     i_reset_n = 1'b0;
    iora_pkg::iora_cfg_t      i_cfg = '1;
    iora_pkg::iora_host_req_t i_host_req = '0;
    iora_pkg::iora_host_rsp_t rsp;
    iora_pkg::iora_back_req_t back_req;
    logic                     done, ready, hv, e;
    logic [31:0]              brd, rd, d, fw, regm [int];
    logic [19:0]              ptr, a;
    logic [3:0]               be;
    logic [1:0]               lag = 2'h0;
    int                       n_fail = 0, samples_checked = 0;
    always #5 i_clock = ~i_clock;
    iora_top u_iora_top (.i_clock, .i_reset_n, .i_cfg, .i_host_req, .i_back_done(done),
        .i_back_rdata(brd), .o_host_ready(ready), .o_host_rsp(rsp), .o_back_req(back_req),
        .o_io_address_pointer(ptr));
    iora_back_model u_iora_back_model (.i_clock, .i_req(back_req), .i_lag(lag), .o_done(done),
        .o_rdata(brd));
    task automatic wrap_up();
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one host access, answer kept in rd and hv
    task automatic acc(input logic [1:0] r, input logic w, input logic [19:0] ad,
                       input logic [3:0] b, input logic [31:0] wd);
        int n;
        n = 0;
        @(negedge i_clock);
        while (!ready && n < 200) begin @(negedge i_clock); n++; end
        i_host_req = {1'b1, w, r, ad, b, wd};
        @(negedge i_clock);
        i_host_req.valid = 1'b0;
        while (!rsp.valid && n < 200) begin @(negedge i_clock); n++; end
        rd = rsp.rdata;
        hv = rsp.hit;
        if (n >= 200) begin n_fail++; wrap_up(); end
    endtask
    initial begin
        void'($urandom(32'h2523252a));
        repeat (16) @(negedge i_clock);
        i_reset_n = 1'b1;
        `CHK(ptr, 20'h0)
        d = $urandom();
        acc(2'h3, 1'b1, 20'h0, 4'hf, d);
        `CHK(ptr, d[19:0])
        acc(2'h3, 1'b1, 20'h0, 4'h7, ~d);
        acc(2'h3, 1'b0, 20'h0, 4'h2, 32'h0);
        `CHK(rd, {12'h0, d[19:0]})
        for (int o = 8; o < 32; o += 4) begin
            acc(2'h3, 1'b1, 20'(o), 4'hf, ~d);
            acc(2'h3, 1'b0, 20'(o), 4'hf, 32'h0);
            `CHK(rd, 32'h0000ffff)
        end
        `CHK(ptr, d[19:0])
        for (int i = 0; i < 12; i++) begin
            lag = 2'($urandom());
            a = (i == 0) ? 20'h1fffc : {3'h0, 15'($urandom()), 2'h0};
            be = (i < 2) ? 4'hf : 4'($urandom());
            d = $urandom();
            if (!regm.exists(a)) regm[a] = 32'h0;
            if (be == 4'hf) regm[a] = d;
            if (i % 2) begin
                acc(2'h3, 1'b1, 20'h0, 4'hf, {12'h0, a});
                acc(2'h3, 1'b1, 20'h4, be, d);
            end else acc(2'h0, 1'b1, a, be, d);
            acc(2'h0, 1'b0, a, 4'($urandom()) | 4'h1, 32'h0);
            `CHK(rd, regm[a])
        end
        for (int l = 0; l < 4; l++) begin
            d = $urandom();
            fw[8*l+:8] = d[8*l+:8];
            acc(2'h3, 1'b1, 20'h0, 4'hf, 32'h80010 | l);
            acc(2'h3, 1'b1, 20'h4, 4'h1 << l, d);
            acc(2'h3, 1'b0, 20'h4, 4'hf, 32'h0);
            `CHK(rd[8*l+:8], d[8*l+:8])
        end
        acc(2'h1, 1'b0, 20'h10, 4'h1, 32'h0);
        `CHK(rd, fw)
        acc(2'h2, 1'b0, 20'h10, 4'h3, 32'h0);
        `CHK(rd, fw)
        for (int k = 0; k < 5; k++) begin
            i_cfg = 5'h1f ^ (5'h1 << k);
            for (int r = 1; r < 4; r++) begin
                e = (r == 1) ? i_cfg.nvm_flash_en & i_cfg.flash_base_nz
                  : (r == 2) ? i_cfg.nvm_flash_en & i_cfg.rom_base_nz
                  : i_cfg.io_base_nz & i_cfg.io_decode_en;
                acc(2'(r), 1'b0, 20'h0, 4'hf, 32'h0);
                `CHK(hv, e)
            end
        end
        i_cfg = '1;
        acc(2'h3, 1'b1, 20'h0, 4'hf, 32'h5);
        i_reset_n = 1'b0;
        @(negedge i_clock);
        `CHK(ptr, 20'h0)
        i_reset_n = 1'b1;
        acc(2'h3, 1'b0, 20'h0, 4'hf, 32'h0);
        `CHK(rd, 32'h0)
        wrap_up();
    end
endmodule
